// File: src/fts_slave.sv
`timescale 1ns/100ps
module fts_slave
    import fts_pkg::*;
(
    // system
    input  wire logic mclk,
    input  wire logic rst_n,
    // two-wire link, scl is the link clock
    input  wire logic scl,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe,
    // straps
    input  wire logic addr_select_bit0,
    input  wire logic addr_select_bit1,
    input  wire logic addr_select_bit2,
    input  wire logic write_protect,
    // status
    output logic      busy
);

    fts_state_t        r;
    fts_state_t        next_r;
    logic [7:0]        link_shift;
    logic              link_low;
    logic [7:0]        mem [MEM_WORDS];
    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0]        wr_data;
    logic              rise;
    logic              start;
    logic              stop;
    logic [ADDR_W-1:0] addr_inc;
    logic [7:0]        rd_next;

    // link domain: shift on every rising scl edge
    always_ff @(posedge scl or negedge rst_n)
    begin
        if (!rst_n)
            link_shift <= 8'h00;
        else
            link_shift <= {link_shift[6:0], sda_i};
    end

    // drive level is set by mclk during scl high, long before the falling edge
    always_ff @(negedge scl or negedge rst_n)
    begin
        if (!rst_n)
            link_low <= 1'b0;
        else
            link_low <= r.drive;
    end

    // only ever pull low; a stop releases the line even with scl parked high
    assign sda_o  = 1'b0;
    assign sda_oe = link_low & (r.phase != PH_IDLE);
    assign busy   = (r.phase != PH_IDLE);

    // history taps only; scl_m[0] and sda_m[0] feed nothing but the next stage
    assign rise  = r.scl_m[1] & ~r.scl_m[2];
    // three stages of scl high guard against skew at the rising clock edge
    assign start = r.scl_m[1] & r.scl_m[2] & r.scl_m[3]
                   & r.sda_m[2] & ~r.sda_m[1];
    assign stop  = r.scl_m[1] & r.scl_m[2] & r.scl_m[3]
                   & ~r.sda_m[2] & r.sda_m[1];

    assign addr_inc = r.addr + ADDR_ONE;
    assign rd_next  = mem[addr_inc];

    always_comb
    begin
        next_r       = r;
        wr_en        = 1'b0;
        wr_addr      = r.addr;
        wr_data      = link_shift;
        next_r.scl_m  = {r.scl_m[2:0], scl};
        next_r.sda_m  = {r.sda_m[1:0], sda_i};
        next_r.wp_m   = {r.wp_m[0], write_protect};
        next_r.pin_m0 = {addr_select_bit2, addr_select_bit1, addr_select_bit0};
        next_r.pin_m1 = r.pin_m0;
        if (stop)
        begin
            next_r.phase = PH_IDLE;
            next_r.cnt   = CNT_ZERO;
            next_r.drive = 1'b0;
        end
        else if (start)
        begin
            next_r.phase = PH_DEV;
            next_r.cnt   = CNT_ZERO;
            next_r.drive = 1'b0;
        end
        else if (rise && r.phase != PH_IDLE)
        begin
            // link_shift is stable for the whole high and low phase after its edge
            if (r.cnt < BIT_LAST)
            begin
                next_r.cnt = r.cnt + CNT_ONE;
                if (r.phase == PH_RDATA)
                    next_r.drive = ~r.rd_byte[3'(BIT_LAST - next_r.cnt)];
            end
            else if (r.cnt == BIT_LAST)
            begin
                next_r.cnt   = ACK_BIT;
                next_r.drive = 1'b1;
                unique case (r.phase)
                    PH_DEV:
                    begin
                        if (link_shift[7:4] != DEV_TYPE || link_shift[3:1] != r.pin_m1)
                        begin
                            next_r.phase = PH_IDLE;
                            next_r.drive = 1'b0;
                        end
                        next_r.dir_rd = link_shift[0];
                    end
                    PH_AHI:
                        next_r.addr[ADDR_W-1:8] = link_shift[ADDR_W-9:0];
                    PH_ALO:
                        next_r.addr[7:0] = link_shift;
                    PH_WDATA:
                    begin
                        // protected data is still acknowledged but discarded
                        wr_en       = ~r.wp_m[1];
                        next_r.addr = addr_inc;
                    end
                    PH_RDATA:
                        next_r.drive = 1'b0;
                    default:
                    begin
                        next_r.phase = PH_IDLE;
                        next_r.drive = 1'b0;
                    end
                endcase
            end
            else
            begin
                next_r.cnt   = CNT_ZERO;
                next_r.drive = 1'b0;
                unique case (r.phase)
                    PH_DEV:
                    begin
                        if (r.dir_rd)
                        begin
                            next_r.phase   = PH_RDATA;
                            next_r.rd_byte = mem[r.addr];
                            next_r.drive   = ~mem[r.addr][7];
                        end
                        else
                            next_r.phase = PH_AHI;
                    end
                    PH_AHI:
                        next_r.phase = PH_ALO;
                    PH_ALO:
                        next_r.phase = PH_WDATA;
                    PH_WDATA:
                        next_r.phase = PH_WDATA;
                    PH_RDATA:
                    begin
                        next_r.addr = addr_inc;
                        // master nack ends the read and frees the line
                        if (link_shift[0])
                            next_r.phase = PH_IDLE;
                        else
                        begin
                            next_r.rd_byte = rd_next;
                            next_r.drive   = ~rd_next[7];
                        end
                    end
                    default:
                        next_r.phase = PH_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            r <= FTS_STATE_RESET;
        else
            r <= next_r;
    end

    // array has no reset: contents are meant to survive power cycles
    always_ff @(posedge mclk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
    end

endmodule

// File: src/fts_pkg.sv
// Contract
// - device is slave only; it never starts a transfer nor drives the clock line.
// - respond only when received three-bit address code equals the strapped address pins.
// - unconnected address pins read as low through an internal pull-down.
// - data line output is open drain: pull low or release only.
// - sample data on rising clock edge, change driven data only on falling edge.
// - write-protect high rejects every write; memory stays unchanged.
// - write-protect low allows writes everywhere; reads work at either level.
// - unconnected write-protect pin reads as low, so writes stay enabled.
// - data changes only while clock low; changes with clock high mean start/stop.
// - data falling while clock high is a start, beginning a read or write.
// - data rising while clock high is a stop, ending the communication.
// - stop during a read ends the read and enters standby.
// - stop during a write ends write data acceptance and enters standby.
// - no programming wait after a write stop; new transaction accepted at once.
// - storage holds 8,192 byte-wide locations.
// - receiver pulls data low on the ninth clock; transmitter releases it.
// - last address-byte bit selects direction: zero write, one read.
// - device-type or address-code mismatch: no response, back to standby.
package fts_pkg;

    localparam int          MEM_WORDS = 8192;
    localparam int          ADDR_W    = 13;
    localparam logic [3:0]  DEV_TYPE  = 4'hA;
    localparam logic [3:0]  BIT_LAST  = 4'h7;
    localparam logic [3:0]  ACK_BIT   = 4'h8;
    localparam logic [3:0]  CNT_ZERO  = 4'h0;
    localparam logic [3:0]  CNT_ONE   = 4'h1;
    localparam logic [12:0] ADDR_ONE  = 13'h0001;

    typedef enum logic [2:0] {
        PH_IDLE  = 3'h0,
        PH_DEV   = 3'h1,
        PH_AHI   = 3'h3,
        PH_ALO   = 3'h2,
        PH_WDATA = 3'h6,
        PH_RDATA = 3'h5
    } fts_phase_t;

    typedef struct packed {
        logic [3:0]        scl_m;
        logic [2:0]        sda_m;
        logic [1:0]        wp_m;
        logic [2:0]        pin_m0;
        logic [2:0]        pin_m1;
        fts_phase_t        phase;
        logic [3:0]        cnt;
        logic              dir_rd;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        rd_byte;
        logic              drive;
    } fts_state_t;

    localparam fts_state_t FTS_STATE_RESET = '{
        scl_m:   4'hF,
        sda_m:   3'h7,
        wp_m:    2'h0,
        pin_m0:  3'h0,
        pin_m1:  3'h0,
        phase:   PH_IDLE,
        cnt:     4'h0,
        dir_rd:  1'b0,
        addr:    13'h0000,
        rd_byte: 8'h00,
        drive:   1'b0
    };

endpackage

// File: testbench/fts_slave_assertions.sv
`timescale 1ns/100ps
module fts_slave_assertions
(
    // watched ports
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic busy
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    a_open_drain: assert property (sda_o == 1'b0) else $error("drives high");
    a_idle_release: assert property (!busy |-> !sda_oe) else $error("drive while idle");
    a_start_busy: assert property ($fell(sda_i) && scl && $past(scl, 3) |-> ##[1:6] busy)
        else $error("start missed");
    a_stop_idle: assert property ($rose(sda_i) && scl && $past(scl, 3) |-> ##[1:6] !busy)
        else $error("stop missed");
    a_busy_cause: assert property ($rose(busy) |-> scl && !sda_i)
        else $error("busy without start");
    a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl) else $error("rise, clock high");
    a_oe_fall_low: assert property ($fell(sda_oe) |-> !scl || !busy)
        else $error("fall, clock high");
    a_oe_stable_high: assert property (scl && $past(scl) && busy |-> $stable(sda_oe))
        else $error("change, clock high");
endmodule
bind fts_slave fts_slave_assertions i_chk (.mclk(mclk), .rst_n(rst_n), .scl(scl),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .busy(busy));

// File: testbench/fts_master_model.sv
`timescale 1ns/100ps
module fts_master_model
(
    // bus toward the slave
    output logic      scl,
    output logic      pull,
    input  wire logic sda
);
    // quarter bit; keeps scl high well above the slave's sync guard
    localparam realtime Q = 390;
    initial
    begin
        scl = 1'b1;
        pull = 1'b0;
    end
    // pull a then b (1 pulls sda low) around a high clock: (0,1) start, (1,0) stop
    task automatic edge_seq(input logic a, input logic b);
        scl = 1'b0;
        #Q pull = a;
        #Q scl = 1'b1;
        #Q pull = b;
        #Q;
    endtask
    task automatic bit_io(input logic b, output logic r);
        scl = 1'b0;
        #Q pull = !b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q;
    endtask
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
        output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(a, ack);
    endtask
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import fts_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [2:0]  pins = 3'h0;
    logic        wp = 1'b0;
    wire         scl, m_pull, sda_oe, sda_o, busy;
    wire         sda = !(m_pull | (sda_oe & !sda_o)); // pull-up resolves the line
    int          err_count = 0;
    int          n_checks = 0;
    logic [7:0]  q, d0, d1, r0, r1;
    logic        ack;
    logic [12:0] a;
    always #12.5 mclk = !mclk;
    fts_slave i_dut (.mclk(mclk), .rst_n(rst_n), .scl(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .addr_select_bit0(pins[0]), .addr_select_bit1(pins[1]),
        .addr_select_bit2(pins[2]), .write_protect(wp), .busy(busy));
    fts_master_model i_mst (.scl(scl), .pull(m_pull), .sda(sda));
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic idle_chk();
        // look just past the edge so the registered busy has settled
        for (int i = 0; i < 8 && busy !== 1'b0; i++)
        begin
            @(posedge mclk);
            #1;
        end
        chk({7'h0, busy}, 8'h00);
        if (busy !== 1'b0)
            tally_and_finish();
    endtask
    task automatic dev(input logic [3:0] ty, input logic [2:0] code, input logic rd);
        i_mst.edge_seq(1'b0, 1'b1);
        i_mst.xfer({ty, code, rd}, 1'b1, q, ack);
    endtask
    task automatic setup(input logic [12:0] ad);
        dev(DEV_TYPE, pins, 1'b0);
        chk({7'h0, ack}, 8'h00);
        i_mst.xfer({3'h0, ad[12:8]}, 1'b1, q, ack);
        i_mst.xfer(ad[7:0], 1'b1, q, ack);
        chk({7'h0, ack}, 8'h00);
    endtask
    task automatic wr2(input logic [12:0] ad, input logic [7:0] x0, input logic [7:0] x1);
        setup(ad);
        i_mst.xfer(x0, 1'b1, q, ack);
        i_mst.xfer(x1, 1'b1, q, ack);
        chk({7'h0, ack}, 8'h00);
        i_mst.edge_seq(1'b1, 1'b0);
        idle_chk();
    endtask
    initial
    begin
        void'($urandom(69735));
        repeat (6) @(posedge mclk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        for (int n = 0; n < 3; n++)
        begin
            pins = 3'($urandom);
            d0 = 8'($urandom);
            d1 = 8'($urandom);
            a = (n == 0) ? 13'h1FFF : 13'($urandom);
            wp = 1'b0;
            wr2(a, d0, d1);
            wp = 1'b1;
            // protected bytes are acked but dropped; no wait after the stop
            wr2(a, ~d0, ~d1);
            setup(a);
            dev(DEV_TYPE, pins, 1'b1);
            i_mst.xfer(8'hFF, 1'b0, r0, ack);
            i_mst.xfer(8'hFF, 1'b1, r1, ack);
            i_mst.edge_seq(1'b1, 1'b0);
            idle_chk();
            chk(r0, d0);
            chk(r1, d1);
            dev(DEV_TYPE ^ 4'h1, pins, 1'b0);
            chk({7'h0, ack}, 8'h01);
            dev(DEV_TYPE, pins ^ 3'($urandom_range(1, 7)), 1'b1);
            chk({7'h0, ack}, 8'h01);
            i_mst.edge_seq(1'b1, 1'b0);
            idle_chk();
            $display("test %0d done", n);
        end
        tally_and_finish();
    end
endmodule
